// ### core/dbdac_host.sv
// host-side load controller driving a double-buffered 10-bit converter
// Overview of operation
// RQ1: device loads ten bits, then two bits
// RQ2: high byte goes out first
// RQ3: auto mode: first byte only fills input latch
// RQ4: auto mode: second byte fills and transfers
// RQ5: cpu mode: two writes, third write transfers
// RQ6: transfer strobe low only on third write
// RQ7: external trigger alone times the transfer
// RQ8: wide bus uses upper ten lines
// RQ9: wide bus keeps byte select high
// RQ10: device register follows latch while strobe low
// RQ11: device register holds when strobe rises
// RQ12: byte select and strobe share one address bit
// RQ13: chip select covers both write strobes
// RQ14: port scheme holds chip select low
// RQ15: port scheme: word out, then pulsed transfer
// RQ16: data pins come from a holding register
// RQ17: device ignores writes without chip select
`timescale 1ns/10ps
`default_nettype none
module dbdac_host
  import dbdac_pkg::*;
#(
  parameter int unsigned WORD_W = WORD_BITS,
  parameter int unsigned BUS_W  = BUS_BITS
) (
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              ce_i,
  // user request
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic [2:0]        req_mode_i,
  input  wire logic [WORD_W-1:0] req_word_i,
  // user status
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   err_o,
  // external transfer trigger pin, active low, asynchronous
  input  wire logic              ext_update_n_i,
  // converter pins
  output logic [BUS_W-1:0]       db_o,
  output logic                   cs_n_o,
  output logic                   wr_n_o,
  output logic                   byte_select_o,
  output logic                   transfer_strobe_n_o
);
  // the sequencing assumes the 10-bit, two-byte split and a wide bus
  if (WORD_W != WORD_BITS || BUS_W < WIDE_LSB + WORD_W) begin : g_check
    $error("dbdac_host: WORD_W must be 10 and BUS_W at least 16");
  end

  typedef enum logic [4:0] {
    S_IDLE   = 5'h01,  // waiting for a request
    S_TRIG   = 5'h02,  // latch full, waiting for the external trigger
    S_SETUP  = 5'h04,  // address and data settle before the strobe
    S_STROBE = 5'h08,  // write and/or transfer strobe low
    S_HOLD   = 5'h10   // data held after the strobe rises
  } dbdac_state_t;

  dbdac_state_t      state;       // sequencer state
  dbdac_mode_t       mode;        // mode of the running request
  logic [WORD_W-1:0] word;        // word of the running request
  logic [1:0]        step;        // write or transfer step in the sequence
  logic [CNT_W-1:0]  cnt;         // phase counter
  logic [1:0]        last_step;   // final step of the current mode
  logic              step_wr;     // this step pulses the write strobe
  logic              step_transfer_strobe_n;   // this step pulses the transfer strobe
  logic              step_bs;     // byte select level of this step
  logic              mode_ok;     // requested mode code is legal
  logic              trig_fall;   // synchronised trigger edge
  logic [1:0]        pin_step;    // step shown on the pins

  // trigger pin crosses in through three flops
  dbdac_sync u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .pin_i   (ext_update_n_i),
    .level_o (),
    .fall_o  (trig_fall)
  );

  assign req_ready_o = (state == S_IDLE);  // handshake may be combinational
  assign mode_ok     = (req_mode_i <= 3'(DBDAC_PORT));

  // per-mode step table
  always_comb begin
    last_step = STEP_FIRST;
    step_wr   = 1'b1;
    step_transfer_strobe_n = 1'b0;
    step_bs   = (step == STEP_FIRST);  // RQ12
    unique case (mode)
      DBDAC_AUTO: begin
        last_step = STEP_SECOND;
        step_transfer_strobe_n = (step == STEP_SECOND);  // RQ12
      end
      DBDAC_CPU: begin
        last_step = STEP_THIRD;
        step_transfer_strobe_n = (step == STEP_THIRD);  // RQ5 RQ6
      end
      DBDAC_EXT: begin
        last_step = STEP_THIRD;
        step_wr   = (step != STEP_THIRD);  // third step is transfer only RQ7
        step_transfer_strobe_n = (step == STEP_THIRD);
      end
      DBDAC_WIDE: begin
        step_bs   = 1'b1;  // RQ9
        step_transfer_strobe_n = 1'b1;  // single buffered: update with the write
      end
      DBDAC_PORT: begin
        last_step = STEP_SECOND;
        step_bs   = 1'b1;
        step_wr   = (step == STEP_FIRST);
        step_transfer_strobe_n = (step == STEP_SECOND);  // RQ15
      end
      default: begin
        last_step = STEP_FIRST;  // not reachable, illegal codes refused
      end
    endcase
  end

  // request capture and sequencer
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= S_IDLE;
      mode  <= DBDAC_AUTO;
      word  <= '0;
      step  <= STEP_FIRST;
      cnt   <= '0;
    end else if (ce_i) begin
      unique case (state)
        S_IDLE: begin
          if (req_valid_i && mode_ok) begin
            mode  <= dbdac_mode_t'(req_mode_i);
            word  <= req_word_i;
            step  <= STEP_FIRST;
            cnt   <= CNT_W'(SETUP_CYC - 1);
            state <= S_SETUP;
          end
        end
        S_TRIG: begin
          // an edge seen before this state is not remembered
          if (trig_fall) begin
            cnt   <= CNT_W'(SETUP_CYC - 1);
            state <= S_SETUP;  // RQ7
          end
        end
        S_SETUP: begin
          cnt <= cnt - 1'b1;
          if (cnt == '0) begin
            cnt   <= CNT_W'(STROBE_CYC - 1);
            state <= S_STROBE;
          end
        end
        S_STROBE: begin
          cnt <= cnt - 1'b1;
          if (cnt == '0) begin
            cnt   <= CNT_W'(HOLD_CYC - 1);
            state <= S_HOLD;
          end
        end
        S_HOLD: begin
          cnt <= cnt - 1'b1;
          if (cnt == '0) begin
            if (step == last_step) begin
              state <= S_IDLE;
            end else begin
              step <= step + 1'b1;
              cnt  <= CNT_W'(SETUP_CYC - 1);
              // external mode waits for its trigger before the transfer
              state <= (mode == DBDAC_EXT && step == STEP_SECOND) ? S_TRIG : S_SETUP;
            end
          end
        end
      endcase
    end
  end

  // user status: done and error pulses, busy level
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      done_o <= 1'b0;
      err_o  <= 1'b0;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= (state == S_HOLD) && (cnt == '0) && (step == last_step);
      err_o  <= (state == S_IDLE) && req_valid_i && !mode_ok;  // dropped
      busy_o <= (state != S_IDLE);
    end
  end

  // pin registers, one cycle behind the sequencer; the registered bus keeps
  // the converter inputs quiet between strobes RQ16
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      db_o                <= '0;
      cs_n_o              <= 1'b1;
      wr_n_o              <= 1'b1;
      byte_select_o       <= 1'b1;
      transfer_strobe_n_o <= 1'b1;
      pin_step            <= STEP_FIRST;
    end else if (ce_i) begin
      pin_step            <= step;
      wr_n_o              <= !(state == S_STROBE && step_wr);
      transfer_strobe_n_o <= !(state == S_STROBE && step_transfer_strobe_n);  // RQ6 RQ12
      // select spans setup to hold of each write; port mode holds it
      cs_n_o <= !(((state == S_SETUP || state == S_STROBE || state == S_HOLD) && step_wr)
                  || (mode == DBDAC_PORT && state != S_IDLE));  // RQ13 RQ14
      if (state == S_SETUP) begin
        byte_select_o <= step_bs;
        db_o          <= '0;
        if (mode == DBDAC_WIDE || mode == DBDAC_PORT) begin
          db_o[WIDE_LSB +: WORD_W] <= word;  // upper ten lines RQ8 RQ15
        end else if (step == STEP_FIRST) begin
          db_o[BYTE_BITS-1:0] <= word[WORD_W-1 -: BYTE_BITS];  // RQ2
        end else begin
          db_o[LOW_PAIR_LSB +: 2] <= word[1:0];  // low pair on top lines
        end
      end
    end
  end

  // checks
  default clocking dbdac_cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  cs_covers_wr_a: assert property (!wr_n_o |-> !cs_n_o) // RQ13
    else $error("write strobe without chip select");
  transfer_strobe_n_third_a: assert property (
    (mode == DBDAC_CPU && !transfer_strobe_n_o) |-> (!wr_n_o && pin_step == STEP_THIRD)) // RQ6
    else $error("transfer strobe outside the third write");
  cpu_two_fill_a: assert property (
    ((mode == DBDAC_CPU || mode == DBDAC_EXT) && !wr_n_o && pin_step != STEP_THIRD)
      |-> transfer_strobe_n_o) // RQ5
    else $error("transfer during a fill write");
  auto_pair_a: assert property (
    (mode == DBDAC_AUTO && !wr_n_o) |-> (byte_select_o == transfer_strobe_n_o)) // RQ12
    else $error("byte select and transfer disagree");
  high_first_a: assert property (
    (!wr_n_o && pin_step == STEP_FIRST && (mode == DBDAC_AUTO || mode == DBDAC_CPU))
      |-> (byte_select_o && db_o[BYTE_BITS-1:0] == word[WORD_W-1 -: BYTE_BITS])) // RQ2
    else $error("first write is not the high byte");
  wide_lines_a: assert property (
    (mode == DBDAC_WIDE && !wr_n_o) |-> (db_o[WIDE_LSB +: WORD_W] == word)) // RQ8
    else $error("wide word not on upper lines");
  wide_select_a: assert property ((mode == DBDAC_WIDE && !wr_n_o) |-> byte_select_o) // RQ9
    else $error("byte select low on wide write");
  ext_trigger_a: assert property (
    (state == S_SETUP && $past(state) == S_TRIG) |-> $past(trig_fall)) // RQ7
    else $error("external transfer without trigger");
  port_select_a: assert property (
    (mode == DBDAC_PORT && !transfer_strobe_n_o) |-> (!cs_n_o && wr_n_o)) // RQ14 RQ15
    else $error("port transfer without held select");
  bus_steady_a: assert property ((!wr_n_o && $past(!wr_n_o)) |-> $stable(db_o)) // RQ16
    else $error("data moved under write strobe");

  auto_done_c: cover property (mode == DBDAC_AUTO && !transfer_strobe_n_o ##[1:40] done_o);
  cpu_third_c: cover property (mode == DBDAC_CPU && !transfer_strobe_n_o);
  ext_trig_c:  cover property (state == S_TRIG ##1 state == S_SETUP);
  wide_done_c: cover property (mode == DBDAC_WIDE && done_o);
endmodule // dbdac_host
`default_nettype wire

// ### core/dbdac_pkg.sv
// constants and types shared by the double-buffered converter load controller
package dbdac_pkg;
  // clock rate and pin timing (times in ns, counts derived and rounded up)
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned T_SETUP_NS     = 40;
  localparam int unsigned T_STROBE_NS    = 250;
  localparam int unsigned T_HOLD_NS      = 20;
  localparam int unsigned SETUP_CYC      = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STROBE_CYC     = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOLD_CYC       = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W          = 8;
  // word and bus layout
  localparam int unsigned WORD_BITS      = 10;
  localparam int unsigned BUS_BITS       = 16;
  localparam int unsigned BYTE_BITS      = 8;
  localparam int unsigned WIDE_LSB       = 6;
  localparam int unsigned LOW_PAIR_LSB   = 6;
  // step numbers of each sequence
  localparam logic [1:0]  STEP_FIRST     = 2'h0;
  localparam logic [1:0]  STEP_SECOND    = 2'h1;
  localparam logic [1:0]  STEP_THIRD     = 2'h2;
  // synchroniser reset level of the idle-high trigger pin
  localparam logic        SYNC_RST_LEVEL = 1'b1;

  // transfer modes requested by the user side
  typedef enum logic [2:0] {
    DBDAC_AUTO = 3'h0,  // two bytes, update on the second
    DBDAC_CPU  = 3'h1,  // two bytes, update on a third write
    DBDAC_EXT  = 3'h2,  // two bytes, update on the external trigger
    DBDAC_WIDE = 3'h3,  // one 10-bit write on the wide bus
    DBDAC_PORT = 3'h4   // two-port adapter, select held, pulsed update
  } dbdac_mode_t;
endpackage : dbdac_pkg

// ### core/dbdac_sync.sv
// three-stage synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/10ps
`default_nettype none
module dbdac_sync
  import dbdac_pkg::*;
(
  // clock, reset, enable
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  // asynchronous pin
  input  wire logic pin_i,
  // synchronised results
  output logic      level_o,
  output logic      fall_o
);
  logic meta;   // first stage, read only by the second
  logic sync2;  // second stage
  logic sync3;  // third stage

  // shift chain; reset to the idle-high level
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta  <= SYNC_RST_LEVEL;
      sync2 <= SYNC_RST_LEVEL;
      sync3 <= SYNC_RST_LEVEL;
    end else if (ce_i) begin
      meta  <= pin_i;
      sync2 <= meta;
      sync3 <= sync2;
    end
  end

  // accept a change only when stages two and three agree
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      level_o <= SYNC_RST_LEVEL;
      fall_o  <= 1'b0;
    end else if (ce_i) begin
      fall_o <= 1'b0;
      if (sync2 == sync3) begin
        level_o <= sync3;
        fall_o  <= level_o && !sync3;  // one pulse per accepted fall
      end
    end
  end
endmodule // dbdac_sync
`default_nettype wire

// ### verification/dbdac_dev_model.sv
// behavioural model of the converter's input latch and output register
`timescale 1ns/10ps
`default_nettype none
module dbdac_dev_model (
  // converter pins as wired by the bench
  input  wire logic [9:0] din_i,
  input  wire logic       cs_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       byte_select_i,
  input  wire logic       transfer_strobe_n_i,
  // latch contents, seen by the bench only
  output logic      [9:0] in_latch_o,
  output logic      [9:0] dac_reg_o
);
  // input latch: open while selected and written, else holds
  always @* begin
    if (!cs_n_i && !wr_n_i) begin
      if (byte_select_i) begin
        in_latch_o = din_i;
      end else begin
        in_latch_o[1:0] = din_i[1:0];
      end
    end
  end

  // output register: follows the input latch while the strobe is low, holds after
  // no chip select term, so an external trigger alone can move the word
  always @* begin
    if (!transfer_strobe_n_i) begin
      dac_reg_o = in_latch_o;
    end
  end
endmodule  // dbdac_dev_model
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the converter load controller
`timescale 1ns/10ps
`default_nettype none
module testbench
  import dbdac_pkg::*;
;
  // one write step in cycles, from the package timing
  localparam int STEP = SETUP_CYC + STROBE_CYC + HOLD_CYC;
  // stimulus
  logic        clk_i          = 1'b0;
  logic        reset_i        = 1'b1;
  logic        req_valid_i    = 1'b0;
  logic [2:0]  req_mode_i     = 3'h0;
  logic [9:0]  req_word_i     = 10'h000;
  logic        ext_update_n_i = 1'b1;
  // design outputs
  logic        req_ready_o, busy_o, done_o, err_o;
  logic [15:0] db_o;
  logic        cs_n_o, wr_n_o, byte_select_o, transfer_strobe_n_o;
  // device side
  wire  logic [9:0] dev_din;
  logic [9:0]  in_latch, dac_reg, last;
  logic        wide_map = 1'b0;
  // bookkeeping
  int          errors = 0, cmp_count = 0, cyc = 0, take_cyc = 0, lat, wr_falls, xf_falls;

  dbdac_host dbdac_host_i (.clk_i(clk_i), .reset_i(reset_i), .ce_i(1'b1),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_mode_i(req_mode_i),
    .req_word_i(req_word_i), .busy_o(busy_o), .done_o(done_o), .err_o(err_o),
    .ext_update_n_i(ext_update_n_i), .db_o(db_o), .cs_n_o(cs_n_o), .wr_n_o(wr_n_o),
    .byte_select_o(byte_select_o), .transfer_strobe_n_o(transfer_strobe_n_o));

  // byte wiring puts the pair on the top two lines; wide and port use the upper ten
  assign dev_din = wide_map ? db_o[15:6] : {db_o[7:0], db_o[7:6]};
  dbdac_dev_model dbdac_dev_model_i (.din_i(dev_din), .cs_n_i(cs_n_o), .wr_n_i(wr_n_o),
    .byte_select_i(byte_select_o), .transfer_strobe_n_i(transfer_strobe_n_o),
    .in_latch_o(in_latch), .dac_reg_o(dac_reg));

  // clock and cycle count
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;
  // strobe counters, cleared per test
  always @(negedge wr_n_o) wr_falls++;
  always @(negedge transfer_strobe_n_o) xf_falls++;

  // shared mismatch report
  task automatic judge(input logic ok, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (!ok) begin
      errors++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic check_word(input logic [9:0] got, input logic [9:0] exp);
    judge(got === exp, {22'h0, got}, {22'h0, exp});
  endtask
  task automatic check_bit(input logic got, input logic exp);
    judge(got === exp, {31'h0, got}, {31'h0, exp});
  endtask
  task automatic check_num(input int got, input int exp);
    judge(got == exp, got, exp);
  endtask

  // present a request and hold it until the take edge
  task automatic start_req(input logic [2:0] mode, input logic [9:0] word);
    wide_map = (mode == DBDAC_WIDE) || (mode == DBDAC_PORT);
    wr_falls = 0;
    xf_falls = 0;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_mode_i  <= mode;
    req_word_i  <= word;
    do @(negedge clk_i); while (req_ready_o !== 1'b1);
    take_cyc = cyc + 1;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
  endtask
  // wait at negedges until k edges past the take
  task automatic at_cyc(input int k);
    while (cyc - take_cyc < k) @(negedge clk_i);
  endtask
  // bounded wait for the completion pulse; done is seen n*STEP edges past the take
  task automatic wait_done();
    do @(negedge clk_i); while (done_o !== 1'b1 && cyc - take_cyc < 600);
    lat = cyc - take_cyc;
  endtask
  // trigger pulse, long enough to pass the pin filter
  task automatic pulse_trigger();
    @(posedge clk_i);
    ext_update_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    ext_update_n_i <= 1'b1;
  endtask

  // single write on the wide bus
  task automatic test_wide(input logic [9:0] w);
    start_req(DBDAC_WIDE, w);
    wait_done();
    check_num(lat, STEP);
    check_word(dac_reg, w);
    check_num(wr_falls, 1);
    last = w;
    $display("wide test finished");
  endtask
  // two bytes, update with the second
  task automatic test_auto(input logic [9:0] w);
    start_req(DBDAC_AUTO, w);
    at_cyc(STEP + 2);
    check_word(dac_reg, last);
    check_word(in_latch, {w[9:2], w[9:8]});
    check_bit(busy_o, 1'b1);
    wait_done();
    check_num(lat, 2 * STEP);
    check_word(dac_reg, w);
    check_num(wr_falls, 2);
    check_num(xf_falls, 1);
    last = w;
    $display("auto test finished");
  endtask
  // two bytes, update on a third write
  task automatic test_cpu(input logic [9:0] w);
    start_req(DBDAC_CPU, w);
    at_cyc(2 * STEP + 1);
    check_word(in_latch, w);
    check_word(dac_reg, last);
    wait_done();
    check_num(lat, 3 * STEP);
    check_word(dac_reg, w);
    check_num(wr_falls, 3);
    check_num(xf_falls, 1);
    last = w;
    $display("cpu test finished");
  endtask
  // two bytes, update on the trigger; an early trigger must be ignored
  task automatic test_ext(input logic [9:0] w);
    start_req(DBDAC_EXT, w);
    at_cyc(5);
    pulse_trigger();
    at_cyc(2 * STEP + 8);
    check_word(in_latch, w);
    check_word(dac_reg, last);
    pulse_trigger();
    wait_done();
    check_bit(done_o, 1'b1);
    check_word(dac_reg, w);
    check_num(wr_falls, 2);
    check_num(xf_falls, 1);
    last = w;
    $display("ext test finished");
  endtask
  // two-port scheme: word out, then a pulsed transfer
  task automatic test_port(input logic [9:0] w);
    start_req(DBDAC_PORT, w);
    wait_done();
    check_num(lat, 2 * STEP);
    check_word(dac_reg, w);
    check_num(wr_falls, 1);
    check_num(xf_falls, 1);
    last = w;
    $display("port test finished");
  endtask
  // illegal codes: dropped with an error pulse, pins untouched
  task automatic test_illegal();
    for (int m = 5; m < 8; m++) begin
      start_req(m[2:0], 10'h001);
      @(negedge clk_i);
      check_bit(err_o, 1'b1);
      check_bit(busy_o, 1'b0);
      repeat (4) @(negedge clk_i);
      check_num(wr_falls, 0);
      check_word(dac_reg, last);
    end
    $display("illegal test finished");
  endtask

  // closing report, the only exit
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence; wide first so the output register holds a known word
  initial begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    check_bit(cs_n_o, 1'b1);
    check_bit(transfer_strobe_n_o, 1'b1);
    check_bit(req_ready_o, 1'b1);
    test_wide(10'h3C5);
    test_auto(10'h15A);
    test_cpu(10'h2D3);
    test_ext(10'h0E9);
    test_port(10'h316);
    test_illegal();
    give_verdict();
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge clk_i);
    errors++;
    give_verdict();
  end
endmodule  // testbench
`default_nettype wire
